// File: dv/l2bf_forward_properties.sv
// Port properties of the forwarding engine, bound to its top module
`timescale 1ns/100ps
module l2bf_forward_properties
  import l2bf_pkg::*;
#(
  parameter int AGE_TICK_CYCLES = AGE_TICK_CYC
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             desc_valid,
  input wire logic [PW-1:0]    desc_port,
  input wire logic [47:0]      desc_da,
  input wire logic [LW-1:0]    desc_len,
  input wire logic             desc_fcs_ok,
  input wire logic             fwd_valid,
  input wire logic [NPORT-1:0] fwd_mask,
  input wire logic             fwd_drop,
  input wire logic             fwd_flood,
  input wire logic             fwd_trunc,
  input wire logic             fwd_bad_fcs
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_frame;
    desc_valid;
  endsequence
  AST_APB_ONE_CYCLE:
    assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  AST_APB_CAUSE:
    assert property (pready |-> penable && $past(psel && !penable))
    else $error("pready without a preceding setup");
  AST_FWD_LATENCY:
    assert property (s_frame |=> fwd_valid)
    else $error("fwd_valid missing after descriptor");
  AST_FWD_CAUSE:
    assert property (fwd_valid |-> $past(desc_valid))
    else $error("fwd_valid without descriptor");
  AST_DROP_EMPTY:
    assert property (fwd_valid && fwd_drop |-> fwd_mask == '0)
    else $error("dropped frame has egress ports");
  AST_FLOOD_NOT_INGRESS:
    assert property (s_frame ##1 fwd_flood |-> !fwd_mask[$past(desc_port)])
    else $error("flood includes ingress port");
  AST_UNICAST_ONEHOT:
    assert property (fwd_valid && !fwd_flood && !fwd_drop |-> $onehot(fwd_mask))
    else $error("unicast mask not one port");
  AST_RUNT_DROP:
    assert property (desc_valid && desc_len < MIN_LEN |=> fwd_drop)
    else $error("short frame not dropped");
  AST_OVERLONG_CUT:
    assert property (desc_valid && desc_len > JUMBO_MAX
      |=> fwd_drop || (fwd_trunc && fwd_bad_fcs))
    else $error("overlong frame not cut with bad check");
  AST_BAD_FCS_KEPT:
    assert property (desc_valid && !desc_fcs_ok |=> fwd_drop || fwd_bad_fcs)
    else $error("bad check sequence not carried");
  AST_BCAST_FLOOD:
    assert property (desc_valid && desc_da == BCAST |=> fwd_drop || fwd_flood)
    else $error("broadcast not flooded");
endmodule

bind l2bf_forward l2bf_forward_properties #(
  .AGE_TICK_CYCLES(AGE_TICK_CYCLES)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .desc_valid(desc_valid), .desc_port(desc_port),
  .desc_da(desc_da), .desc_len(desc_len), .desc_fcs_ok(desc_fcs_ok),
  .fwd_valid(fwd_valid), .fwd_mask(fwd_mask), .fwd_drop(fwd_drop),
  .fwd_flood(fwd_flood), .fwd_trunc(fwd_trunc), .fwd_bad_fcs(fwd_bad_fcs)
);

// File: dv/l2bf_host_model.sv
// Model of the attached hosts, issuing one frame descriptor per call
`timescale 1ns/100ps
module l2bf_host_model
  import l2bf_pkg::*;
(
  input  wire logic     pclk,
  output logic          desc_valid,
  output logic [PW-1:0] desc_port,
  output logic [47:0]   desc_da,
  output logic [47:0]   desc_sa,
  output logic          desc_tagged,
  output logic [11:0]   desc_vid,
  output logic [2:0]    desc_cos,
  output logic [15:0]   desc_etype,
  output logic [LW-1:0] desc_len,
  output logic          desc_fcs_ok,
  output logic          desc_ip_mc,
  output logic [22:0]   desc_ip_grp
);
  initial begin
    desc_valid = 1'b0;
    {desc_port, desc_da, desc_sa, desc_tagged, desc_vid, desc_cos} = '0;
    {desc_etype, desc_len, desc_fcs_ok, desc_ip_mc, desc_ip_grp} = '0;
  end

  // Gap lets a host be slow; tag priority is always 5
  task automatic send(input logic [PW-1:0] p, input logic [47:0] da, sa,
                      input logic [LW-1:0] len, input logic ok, tg,
                      input logic [11:0] vid, input logic mc,
                      input logic [22:0] g, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    desc_valid <= 1'b1;
    {desc_port, desc_da, desc_sa, desc_len} <= {p, da, sa, len};
    {desc_fcs_ok, desc_tagged, desc_vid, desc_cos} <= {ok, tg, vid, 3'h5};
    {desc_etype, desc_ip_mc, desc_ip_grp} <= {16'h0800, mc, g};
    @(posedge pclk);
    desc_valid <= 1'b0;
    // Idle fields flip so stale values never look like a frame
    {desc_da, desc_sa, desc_len} <= ~{desc_da, desc_sa, desc_len};
  endtask
endmodule

// File: dv/tb_top.sv
// Register and forwarding tests of the bridge forwarding engine
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top
  import l2bf_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic desc_valid, desc_tagged, desc_fcs_ok, desc_ip_mc;
  logic [PW-1:0] desc_port;
  logic [47:0] desc_da, desc_sa;
  logic [11:0] desc_vid;
  logic [2:0] desc_cos, fwd_cos;
  logic [15:0] desc_etype;
  logic [LW-1:0] desc_len;
  logic [22:0] desc_ip_grp;
  logic fwd_valid, fwd_drop, fwd_flood, fwd_trunc, fwd_bad_fcs;
  logic [NPORT-1:0] fwd_mask;
  logic [VW-1:0] fwd_vid;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [11:0] RA [8] = '{{4'h0, CTRL_OFF}, {4'h0, MUT_OFF},
    {4'h0, FCOE_OFF}, {4'h0, PROTO_OFF}, {4'h0, AGE_OFF},
    {4'h0, PCFG_REG, 5'h0}, {4'h0, PVLAN_REG, 5'h0}, {4'h0, STAT_OFF}};
  localparam logic [31:0] RV [8] = '{{30'h0, CTRL_RST}, {8'h0, MUT_RST},
    {20'h0, FCOE_RST}, PROTO_RST, AGE_RST, PCFG_RST, PVLAN_RST, 32'h0};

  always #5 pclk = ~pclk;

  l2bf_forward #(.AGE_TICK_CYCLES(8)) u_l2bf_forward (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .desc_valid(desc_valid),
    .desc_port(desc_port), .desc_da(desc_da), .desc_sa(desc_sa),
    .desc_tagged(desc_tagged), .desc_vid(desc_vid), .desc_cos(desc_cos),
    .desc_etype(desc_etype), .desc_len(desc_len),
    .desc_fcs_ok(desc_fcs_ok), .desc_ip_mc(desc_ip_mc),
    .desc_ip_grp(desc_ip_grp), .fwd_valid(fwd_valid), .fwd_mask(fwd_mask),
    .fwd_vid(fwd_vid), .fwd_cos(fwd_cos), .fwd_drop(fwd_drop),
    .fwd_flood(fwd_flood), .fwd_trunc(fwd_trunc),
    .fwd_bad_fcs(fwd_bad_fcs));

  l2bf_host_model u_hosts (
    .pclk(pclk), .desc_valid(desc_valid), .desc_port(desc_port),
    .desc_da(desc_da), .desc_sa(desc_sa), .desc_tagged(desc_tagged),
    .desc_vid(desc_vid), .desc_cos(desc_cos), .desc_etype(desc_etype),
    .desc_len(desc_len), .desc_fcs_ok(desc_fcs_ok),
    .desc_ip_mc(desc_ip_mc), .desc_ip_grp(desc_ip_grp));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict;
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      mismatches++;
    {rd_q, err_q} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd_q)
  endtask

  task automatic fr(input logic [2:0] p, input logic [47:0] da, sa,
                    input logic [13:0] len = 14'h0064, input logic ok = 1,
                    input logic tg = 0, input logic [11:0] vid = 12'h0,
                    input logic mc = 0, input logic [22:0] g = 23'h0,
                    input int gap = 0);
    u_hosts.send(p, da, sa, len, ok, tg, vid, mc, g, gap);
    #1;
    `CHK("fwd_valid", 1'b1, fwd_valid)
  endtask

  task automatic res(input logic [7:0] mk, input logic dr, fl);
    `CHK("fwd_mask", mk, fwd_mask)
    `CHK("fwd_drop fwd_flood", {dr, fl}, {fwd_drop, fwd_flood})
  endtask

  function automatic logic [47:0] m(input logic [7:0] n);
    return {40'h02_0000_0000, n};
  endfunction

  function automatic logic [11:0] pa(input logic [2:0] r, p);
    return {4'h0, r, p, 2'h0};
  endfunction

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RA[i]) rdchk(RA[i], RV[i]);
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped pslverr", 1'b1, err_q)
    apb(1'b1, {4'h0, STAT_OFF}, 32'h1);
    `CHK("read-only pslverr", 1'b1, err_q)
    apb(1'b1, {4'h0, FCOE_OFF}, 32'h0);
    `CHK("fcoe zero pslverr", 1'b0, err_q)
    rdchk({4'h0, FCOE_OFF}, {20'h0, FCOE_RST});
    $display("test registers done");
    fr(3'h0, m(8'hB2), m(8'hA1));
    res(8'hFE, 1'b0, 1'b1);
    `CHK("fwd_vid", 13'h0001, fwd_vid)
    fr(3'h2, m(8'hA1), m(8'hB2));
    res(8'h01, 1'b0, 1'b0);
    fr(3'h0, m(8'hA1), m(8'hC3));
    res(8'h00, 1'b1, 1'b0);
    fr(3'h3, BCAST, m(8'hD4), 14'h0064, 1, 0, 12'h0, 0, 23'h0, 3);
    res(8'hF7, 1'b0, 1'b1);
    fr(3'h1, m(8'hB2), m(8'hD4), 14'h0064, 1'b0);
    res(8'h04, 1'b0, 1'b0);
    `CHK("fwd_bad_fcs", 1'b1, fwd_bad_fcs)
    fr(3'h1, m(8'hB2), m(8'hE5), 14'h003F);
    res(8'h00, 1'b1, 1'b0);
    rdchk(pa(PERR_REG, 3'h1), 32'h0000_0001);
    fr(3'h1, m(8'hB2), m(8'hE5), 14'h2401);
    `CHK("fwd_trunc fwd_bad_fcs", 2'h3, {fwd_trunc, fwd_bad_fcs})
    fr(3'h1, m(8'hB2), m(8'hE5), 14'h07D0);
    res(8'h00, 1'b1, 1'b0);
    rdchk(pa(PERR_REG, 3'h1), 32'h0001_0002);
    fr(3'h5, m(8'hB2), m(8'hA1));
    fr(3'h2, m(8'hA1), m(8'hB2));
    res(8'h20, 1'b0, 1'b0);
    $display("test forwarding done");
    fr(3'h0, {MC_OUI, 24'h5}, m(8'hA1), 14'h0064, 1, 0, 12'h0, 1, 23'h5);
    res(8'hFE, 1'b0, 1'b1);
    fr(3'h0, {MC_OUI, 24'h5}, m(8'hA1), 14'h0064, 1, 0, 12'h0, 1, 23'h6);
    res(8'h00, 1'b1, 1'b0);
    $display("test multicast done");
    fr(3'h6, BCAST, m(8'hF6), 14'h0064, 1'b1, 1'b1, 12'h001);
    res(8'h00, 1'b1, 1'b0);
    apb(1'b1, pa(PCFG_REG, 3'h6), 32'h0003_0001);
    fr(3'h6, BCAST, m(8'hF6), 14'h0064, 1'b1, 1'b1, 12'h001);
    res(8'hBF, 1'b0, 1'b1);
    `CHK("fwd_cos fwd_vid", 16'hA001, {fwd_cos, fwd_vid})
    fr(3'h6, BCAST, m(8'hF6), 14'h0064, 1'b1, 1'b1, 12'h009);
    res(8'h00, 1'b1, 1'b0);
    apb(1'b1, pa(PCFG_REG, 3'h4), 32'h0000_C002);
    fr(3'h4, BCAST, m(8'h17));
    `CHK("fwd_cos fwd_vid", 16'hC002, {fwd_cos, fwd_vid})
    $display("test tagging done");
    // Limit of two ticks of eight cycles: 40 cycles ages every entry
    apb(1'b1, {4'h0, AGE_OFF}, 32'h0096_0002);
    repeat (40) @(posedge pclk);
    fr(3'h2, m(8'hA1), m(8'hB2));
    res(8'hFB, 1'b0, 1'b1);
    $display("test aging done");
    give_verdict;
  end
endmodule

// File: rtl/l2bf_forward.sv
// Ingress classification and forwarding engine with APB registers
// Operation
// [R1] Unknown destination floods VLAN minus ingress
// [R2] Known destination goes to its port only
// [R3] Egress equal to ingress drops frame
// [R4] Bad FCS frame still forwarded, FCS bad
// [R5] Runt frame dropped, error counter bumped
// [R6] Overlong frame truncated, counted, FCS corrupted
// [R7] Broadcast floods VLAN minus ingress
// [R8] Aged entries removed, then destination floods
// [R9] Moved source replaces entry with new port
// [R10] Full table reuses only aged oldest entries
// [R11] Replacement starts at ninety percent occupancy
// [R12] Jumbo without jumbo MTU dropped, oversize counted
// [R13] Multicast without snooping treated as broadcast
// [R14] Mismatched MAC/IP multicast groups dropped silently
// [R15] Untagged frames get VLAN from port setup
// [R16] Tagged frames need allowed VLAN else drop
// [R17] Accepted tagged frames keep tag unchanged
// [R18] Single FCoE VLAN, 1..4095, default 1002
// [R19] Extended VLAN IDs only with multitenancy
// [R20] Classify by port, protocol or MAC
// [R21] Each port presets VLAN and CoS
// [R22] CoS trust keeps, mutation rewrites CoS
// [R23] Learn source on every frame, reset age; code skips runt, bad tag, bad group, extended VLAN, multicast source
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module l2bf_forward
  import l2bf_pkg::*;
#(
  parameter int AGE_TICK_CYCLES = AGE_TICK_CYC
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          desc_valid,
  input  wire logic [PW-1:0] desc_port,
  input  wire logic [47:0]   desc_da,
  input  wire logic [47:0]   desc_sa,
  input  wire logic          desc_tagged,
  input  wire logic [11:0]   desc_vid,
  input  wire logic [2:0]    desc_cos,
  input  wire logic [15:0]   desc_etype,
  input  wire logic [LW-1:0] desc_len,
  input  wire logic          desc_fcs_ok,
  input  wire logic          desc_ip_mc,
  input  wire logic [22:0]   desc_ip_grp,
  output logic               fwd_valid,
  output logic [NPORT-1:0]   fwd_mask,
  output logic [VW-1:0]      fwd_vid,
  output logic [2:0]         fwd_cos,
  output logic               fwd_drop,
  output logic               fwd_flood,
  output logic               fwd_trunc,
  output logic               fwd_bad_fcs
);
  logic [1:0]        ctrl_reg;
  logic [23:0]       mut_reg;
  logic [11:0]       fcoe_reg;
  logic [31:0]       proto_reg;
  logic [31:0]       macl_reg;
  logic [31:0]       mach_reg;
  logic [31:0]       age_cfg_reg;
  logic [31:0]       pcfg_reg [NPORT];
  logic [31:0]       pvlan_reg [NPORT];
  logic [CW-1:0]     err_reg [NPORT];
  logic [CW-1:0]     ovs_reg [NPORT];

  // APB decode
  wire        setup    = psel && !penable;
  wire        wr_en    = psel && penable && pwrite && pready;
  wire [2:0]  region   = paddr[7:5];
  wire [PW-1:0] rport  = paddr[4:2];
  wire        hi_zero  = paddr[11:8] == 4'h0;
  wire        glob     = hi_zero && region == 3'h0;
  wire        is_pcfg  = hi_zero && region == PCFG_REG;
  wire        is_pvlan = hi_zero && region == PVLAN_REG;
  wire        is_perr  = hi_zero && region == PERR_REG;
  wire        mapped   = glob || is_pcfg || is_pvlan || is_perr;
  wire        bad_wr   = pwrite && (is_perr ||
                         (glob && paddr[7:0] == STAT_OFF));
  wire [TIW:0] occ;
  wire        age_tick;
  wire        lk_hit;
  wire [PW-1:0] lk_port;

  wire [31:0] rd_glob =
    (paddr[7:0] == CTRL_OFF)  ? {30'h0, ctrl_reg} :
    (paddr[7:0] == MUT_OFF)   ? {8'h00, mut_reg} :
    (paddr[7:0] == FCOE_OFF)  ? {20'h0, fcoe_reg} :
    (paddr[7:0] == PROTO_OFF) ? proto_reg :
    (paddr[7:0] == MACL_OFF)  ? macl_reg :
    (paddr[7:0] == MACH_OFF)  ? mach_reg :
    (paddr[7:0] == AGE_OFF)   ? age_cfg_reg :
    {27'h0, occ};
  wire [31:0] rd_data =
    is_pcfg  ? pcfg_reg[rport] :
    is_pvlan ? pvlan_reg[rport] :
    is_perr  ? {ovs_reg[rport], err_reg[rport]} :
    glob     ? rd_glob : 32'h0;

  // Answer one cycle after setup: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= setup && !pwrite ? rd_data : 32'h0;
      pslverr <= setup && (!mapped || bad_wr);
    end
  end

  wire gw = wr_en && glob;
  // A zero FCoE VLAN is outside the legal range and is ignored
  wire fcoe_wr = gw && paddr[7:0] == FCOE_OFF && pwdata[11:0] != 12'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= CTRL_RST;
      mut_reg     <= MUT_RST;
      fcoe_reg    <= FCOE_RST; // [R18]
      proto_reg   <= PROTO_RST;
      macl_reg    <= PROTO_RST;
      mach_reg    <= PROTO_RST;
      age_cfg_reg <= AGE_RST;
    end else begin
      if (gw && paddr[7:0] == CTRL_OFF)  ctrl_reg    <= pwdata[1:0];
      if (gw && paddr[7:0] == MUT_OFF)   mut_reg     <= pwdata[23:0];
      if (fcoe_wr)                       fcoe_reg    <= pwdata[11:0];
      if (gw && paddr[7:0] == PROTO_OFF) proto_reg   <= pwdata;
      if (gw && paddr[7:0] == MACL_OFF)  macl_reg    <= pwdata;
      if (gw && paddr[7:0] == MACH_OFF)  mach_reg    <= pwdata;
      if (gw && paddr[7:0] == AGE_OFF)   age_cfg_reg <= pwdata;
    end
  end

  // Classification of the incoming descriptor
  wire [31:0] pc       = pcfg_reg[desc_port];
  wire        en       = ctrl_reg[CT_EN];
  wire        mt_on    = ctrl_reg[CT_MT];
  wire        mac_cls  = desc_sa == {mach_reg[15:0], macl_reg};
  wire        prot_cls = desc_etype == proto_reg[15:0];
  wire [VW-1:0] cls_vid =
    mac_cls  ? mach_reg[CLS_VLSB +: VW] :
    prot_cls ? proto_reg[CLS_VLSB +: VW] :
    pc[VW-1:0]; // [R20] [R21]
  wire [2:0]  cls_cos  =
    mac_cls  ? mach_reg[CLS_CLSB +: 3] :
    prot_cls ? proto_reg[CLS_CLSB +: 3] :
    pc[PC_COS +: 3]; // [R20] [R21]
  // Tag kept as received when accepted; untagged get the class VLAN
  wire [VW-1:0] vid = desc_tagged ? {1'b0, desc_vid} : cls_vid; // [R15] [R17]

  logic [NPORT-1:0] vmem;
  for (genvar p = 0; p < NPORT; p++) begin : g_vmem
    assign vmem[p] = (vid >= pvlan_reg[p][VW-1:0] &&
                      vid <= pvlan_reg[p][HI_LSB +: VW]) ||
                     vid == pcfg_reg[p][VW-1:0];
  end

  wire tag_drop = desc_tagged &&
                  (!pc[PC_TAG] || !vmem[desc_port]); // [R16]
  wire mt_drop  = !mt_on && vid > VID_STD_MAX; // [R19]
  wire fcoe_drop = desc_etype == FCOE_ETYPE &&
                   vid != {1'b0, fcoe_reg}; // [R18]
  wire runt     = desc_len < MIN_LEN; // [R5]
  wire jumbo    = desc_len > STD_MAX && desc_len <= JUMBO_MAX;
  wire too_long = desc_len > JUMBO_MAX; // [R6]
  wire jumbo_drop = jumbo && !pc[PC_JUMBO]; // [R12]
  wire bcast    = desc_da == BCAST;
  wire is_mc    = desc_da[40];
  wire mc_bad   = is_mc && !bcast && desc_ip_mc &&
                  (desc_da[47:24] != MC_OUI || desc_da[23] ||
                   desc_da[22:0] != desc_ip_grp); // [R14]
  wire mc_flood = is_mc && !pc[PC_SNOOP]; // [R13]
  // Snooped multicast is looked up like unicast, a miss still floods
  wire flood    = bcast || mc_flood || !lk_hit; // [R1] [R7] [R8]
  wire same_port = !flood && lk_port == desc_port; // [R3]

  wire [NPORT-1:0] in_oh  = NPORT'(1) << desc_port;
  wire [NPORT-1:0] uc_oh  = NPORT'(1) << lk_port;
  wire [NPORT-1:0] fl_msk = vmem & ~in_oh; // [R1] [R7]
  wire drop = !en || runt || jumbo_drop || mc_bad || tag_drop ||
              mt_drop || fcoe_drop || same_port;

  wire [2:0] base_cos = (desc_tagged && pc[PC_TRUST]) ?
                        desc_cos : cls_cos; // [R22]
  wire [2:0] out_cos  = pc[PC_MUT] ?
                        mut_reg[3 * base_cos +: 3] : base_cos; // [R22]

  // Frames that failed the basic checks must not pollute the table
  wire ln_en = desc_valid && en && !runt && !mc_bad && !tag_drop &&
               !mt_drop && !desc_sa[40]; // [R23]

  l2bf_tick_div #(
    .CYC (AGE_TICK_CYCLES)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (age_tick)
  );

  l2bf_mac_table u_tbl (
    .pclk     (pclk),
    .presetn  (presetn),
    .lk_mac   (desc_da),
    .lk_vid   (vid),
    .lk_hit   (lk_hit),
    .lk_port  (lk_port),
    .ln_en    (ln_en),
    .ln_mac   (desc_sa),
    .ln_vid   (vid),
    .ln_port  (desc_port),
    .age_tick (age_tick),
    .age_lim  (age_cfg_reg[AW-1:0]),
    .repl_age (age_cfg_reg[31:AW]),
    .occ      (occ)
  );

  // Per-port configuration and error counters
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    wire hit_p = desc_valid && en && desc_port == PW'(p);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pcfg_reg[p]  <= PCFG_RST;
        pvlan_reg[p] <= PVLAN_RST;
      end else begin
        if (wr_en && is_pcfg && rport == PW'(p))
          pcfg_reg[p] <= pwdata;
        if (wr_en && is_pvlan && rport == PW'(p))
          pvlan_reg[p] <= pwdata;
      end
    end
    // Counters saturate rather than wrap so a flood of errors stays visible
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        err_reg[p] <= '0;
        ovs_reg[p] <= '0;
      end else begin
        if (hit_p && (runt || too_long) && ~&err_reg[p])
          err_reg[p] <= err_reg[p] + 1'b1; // [R5] [R6]
        if (hit_p && jumbo_drop && ~&ovs_reg[p])
          ovs_reg[p] <= ovs_reg[p] + 1'b1; // [R12]
      end
    end
  end

  // Forwarding decision, one cycle after the descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid   <= 1'b0;
      fwd_mask    <= '0;
      fwd_vid     <= '0;
      fwd_cos     <= '0;
      fwd_drop    <= 1'b0;
      fwd_flood   <= 1'b0;
      fwd_trunc   <= 1'b0;
      fwd_bad_fcs <= 1'b0;
    end else begin
      fwd_valid   <= desc_valid;
      fwd_mask    <= !desc_valid || drop ? '0 :
                     flood ? fl_msk : uc_oh; // [R1] [R2] [R3]
      fwd_vid     <= vid;
      fwd_cos     <= out_cos;
      fwd_drop    <= desc_valid && drop;
      fwd_flood   <= desc_valid && !drop && flood;
      fwd_trunc   <= desc_valid && !drop && too_long; // [R6]
      fwd_bad_fcs <= desc_valid && !drop &&
                     (!desc_fcs_ok || too_long); // [R4] [R6]
    end
  end
endmodule

// File: rtl/l2bf_mac_table.sv
// Aging address table with lookup, learning and replacement
`timescale 1ns/100ps
module l2bf_mac_table
  import l2bf_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [47:0]   lk_mac,
  input  wire logic [VW-1:0] lk_vid,
  output logic               lk_hit,
  output logic [PW-1:0]      lk_port,
  input  wire logic          ln_en,
  input  wire logic [47:0]   ln_mac,
  input  wire logic [VW-1:0] ln_vid,
  input  wire logic [PW-1:0] ln_port,
  input  wire logic          age_tick,
  input  wire logic [AW-1:0] age_lim,
  input  wire logic [AW-1:0] repl_age,
  output logic [TIW:0]       occ
);
  logic [TDEPTH-1:0] v_reg;
  logic [47:0]       mac_reg [TDEPTH];
  logic [VW-1:0]     vid_reg [TDEPTH];
  logic [PW-1:0]     port_reg [TDEPTH];
  logic [AW-1:0]     age_reg [TDEPTH];
  logic [TDEPTH-1:0] lk_m;
  logic [TDEPTH-1:0] ln_m;
  logic [TIW-1:0]    lk_i;
  logic [TIW-1:0]    ln_i;
  logic [TIW-1:0]    free_i;
  logic [TIW-1:0]    old_i;
  logic [TIW-1:0]    sel_i;
  logic              free_ok;
  logic              ln_do;

  always_comb begin
    lk_i    = '0;
    ln_i    = '0;
    free_i  = '0;
    old_i   = '0;
    free_ok = 1'b0;
    occ     = '0;
    for (int k = TDEPTH - 1; k >= 0; k--) begin
      if (lk_m[k]) lk_i = TIW'(k);
      if (ln_m[k]) ln_i = TIW'(k);
      if (!v_reg[k]) begin
        free_i  = TIW'(k);
        free_ok = 1'b1;
      end
    end
    for (int k = 0; k < TDEPTH; k++) begin
      occ = occ + {{TIW{1'b0}}, v_reg[k]};
      if (age_reg[k] > age_reg[old_i]) old_i = TIW'(k);
    end
  end

  assign lk_hit  = |lk_m;
  assign lk_port = port_reg[lk_i];
  // Oldest entry is taken only once it is old enough; busy ones refresh
  assign sel_i = (|ln_m) ? ln_i :
                 (occ < OCC_THR && free_ok) ? free_i : old_i; // [R11]
  assign ln_do = ln_en && ((|ln_m) || (occ < OCC_THR && free_ok) ||
                 age_reg[old_i] >= repl_age); // [R10]

  for (genvar i = 0; i < TDEPTH; i++) begin : g_ent
    assign lk_m[i] = v_reg[i] && mac_reg[i] == lk_mac &&
                     vid_reg[i] == lk_vid;
    assign ln_m[i] = v_reg[i] && mac_reg[i] == ln_mac &&
                     vid_reg[i] == ln_vid;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        v_reg[i]    <= 1'b0;
        mac_reg[i]  <= '0;
        vid_reg[i]  <= '0;
        port_reg[i] <= '0;
        age_reg[i]  <= '0;
      end else if (ln_do && sel_i == TIW'(i)) begin
        v_reg[i]    <= 1'b1; // [R23]
        mac_reg[i]  <= ln_mac;
        vid_reg[i]  <= ln_vid;
        port_reg[i] <= ln_port; // [R9]
        age_reg[i]  <= '0; // [R10]
      end else if (age_tick && v_reg[i]) begin
        age_reg[i] <= age_reg[i] + 1'b1;
        if (age_reg[i] + 1'b1 >= age_lim) v_reg[i] <= 1'b0; // [R8]
      end
    end
  end
endmodule

// File: rtl/l2bf_pkg.sv
// Shared constants for the layer 2 bridge forwarding engine
package l2bf_pkg;
  localparam int NPORT = 8;
  localparam int PW    = 3;
  localparam int VW    = 13;
  localparam int TDEPTH = 16;
  localparam int TIW   = 4;
  localparam int AW    = 16;
  localparam int CW    = 16;
  localparam int LW    = 14;

  // Register byte offsets, then per-port region numbers decoded from paddr[7:5]
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] MUT_OFF   = 8'h04;
  localparam logic [7:0] FCOE_OFF  = 8'h08;
  localparam logic [7:0] PROTO_OFF = 8'h0C;
  localparam logic [7:0] MACL_OFF  = 8'h10;
  localparam logic [7:0] MACH_OFF  = 8'h14;
  localparam logic [7:0] AGE_OFF   = 8'h18;
  localparam logic [7:0] STAT_OFF  = 8'h1C;
  localparam logic [2:0] PCFG_REG  = 3'h2;
  localparam logic [2:0] PVLAN_REG = 3'h3;
  localparam logic [2:0] PERR_REG  = 3'h4;

  // Field positions
  localparam int CT_EN     = 0;
  localparam int CT_MT     = 1;
  localparam int PC_COS    = 13;
  localparam int PC_TAG    = 16;
  localparam int PC_TRUST  = 17;
  localparam int PC_MUT    = 18;
  localparam int PC_JUMBO  = 19;
  localparam int PC_SNOOP  = 20;
  localparam int HI_LSB    = 16;
  localparam int CLS_VLSB  = 16;
  localparam int CLS_CLSB  = 29;

  // Reset values
  localparam logic [1:0]  CTRL_RST  = 2'h1;
  localparam logic [23:0] MUT_RST   = 24'hFAC688;
  localparam logic [11:0] FCOE_RST  = 12'h3EA;
  localparam logic [31:0] PROTO_RST = 32'h0000_0000;
  localparam logic [31:0] AGE_RST   = 32'h0096_012C;
  localparam logic [31:0] PCFG_RST  = 32'h0000_0001;
  localparam logic [31:0] PVLAN_RST = 32'h0001_0001;

  // Frame limits in bytes
  localparam logic [LW-1:0] MIN_LEN   = 14'h0040;
  localparam logic [LW-1:0] STD_MAX   = 14'h05F2;
  localparam logic [LW-1:0] JUMBO_MAX = 14'h2400;

  localparam logic [15:0] FCOE_ETYPE = 16'h8906;
  localparam logic [23:0] MC_OUI     = 24'h01005E;
  localparam logic [47:0] BCAST      = 48'hFFFF_FFFF_FFFF;
  localparam logic [VW-1:0] VID_STD_MAX = 13'h0FFF;
  localparam logic [TIW:0] OCC_THR = 5'((TDEPTH * 9) / 10);

  // Aging tick timing
  localparam int AGE_TICK_US  = 1000;
  localparam int CLK_MHZ      = 100;
  localparam int AGE_TICK_CYC = AGE_TICK_US * CLK_MHZ;
endpackage

// File: rtl/l2bf_tick_div.sv
// Divider making the one-cycle aging tick enable
`timescale 1ns/100ps
module l2bf_tick_div #(
  parameter int CYC = 100000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  localparam int CNW = $clog2(CYC + 1);
  localparam logic [CNW-1:0] LAST = CNW'(CYC - 1);

  logic [CNW-1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule
